// ---- core/lsab_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module lsab_bank
  import lsab_pkg::*;
#(
  parameter int WAIT0_CYC = LSAB_WAIT0_CYC,
  parameter int WAIT1_CYC = LSAB_WAIT1_CYC,
  parameter int WAIT2_CYC = LSAB_WAIT2_CYC,
  parameter int WAIT3_CYC = LSAB_WAIT3_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  input  wire logic [1:0] sw_oc_i,
  input  wire logic [1:0] sw_ot_i,
  input  wire logic [1:0] sw_pg_i,
  input  wire logic [1:0] sw_limit_i,
  output logic      [1:0] switch_on_o,
  output logic      [1:0] switch_discharge_o,
  output logic            conv_start_o,
  output logic            conv_ref_en_o,
  output logic      [3:0] conv_channel_o,
  input  wire logic       conv_complete_i,
  input  wire logic [9:0] conv_result_i
);

  // Register bank behind the host's management interface. The host
  // reaches six byte registers through a flat address, a one-cycle
  // write strobe and combinational read data. Switch and converter
  // status comes from the analog side through synchronisers; control
  // fields go out to the switches and the converter from flip-flops.
  // Reload, a write of one to the top bit of the spare register,
  // returns every register but a result finishing, or a timeout whose wait in current limit is met, in that cycle to its value after reset,
  // aborts a running conversion and clears both switch timeouts.

  // ---------------------------------------------------------------------
  // Input synchronisers for analog status
  // ---------------------------------------------------------------------
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic [8:0] async_in;
  logic [1:0] oc_s;
  logic [1:0] ot_s;
  logic [1:0] pg_s;
  logic [1:0] lim_s;
  logic       done_s;

  // Switch flags, current-limit levels and the converter's completion
  // come from analog circuits with no relation to this clock. Each bit
  // is resynchronised on its own; the flags are levels, so a skew of
  // one cycle between neighbouring bits is harmless. The result word
  // is not resynchronised: it is only captured once the synchronised
  // completion is seen, two edges after it rose, by which time the
  // converter holds it steady.
  assign async_in = {conv_complete_i, sw_limit_i, sw_pg_i, sw_ot_i, sw_oc_i};

  // Two flip-flops before any logic reads the flags; reset clears
  // both stages so that no false flag shows just after reset
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Fields of the synchronised word, lowest bits first
  assign oc_s   = sync2_reg[1:0];
  assign ot_s   = sync2_reg[3:2];
  assign pg_s   = sync2_reg[5:4];
  assign lim_s  = sync2_reg[7:6];
  assign done_s = sync2_reg[8];

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  logic sel_sw6;
  logic sel_sw7;
  logic sel_conv;
  logic sel_res_lo;
  logic sel_res_hi;
  logic sel_spare;
  logic wr_sw6;
  logic wr_sw7;
  logic wr_conv;
  logic wr_spare;
  logic reload;

  // One select per mapped register, shared by reads and writes
  assign sel_sw6    = (addr_i == LSAB_OFS_SW6);
  assign sel_sw7    = (addr_i == LSAB_OFS_SW7);
  assign sel_conv   = (addr_i == LSAB_OFS_CONV);
  assign sel_res_lo = (addr_i == LSAB_OFS_RES_LO);
  assign sel_res_hi = (addr_i == LSAB_OFS_RES_HI);
  assign sel_spare  = (addr_i == LSAB_OFS_SPARE);

  // A write needs the strobe too; read-only and unmapped addresses
  // have no write decode at all, so such writes find no target
  assign wr_sw6   = wr_en_i && sel_sw6;
  assign wr_sw7   = wr_en_i && sel_sw7;
  assign wr_conv  = wr_en_i && sel_conv;
  assign wr_spare = wr_en_i && sel_spare;
  // Reload acts in the cycle of the write; bit 7 is never stored
  assign reload   = wr_spare && wdata_i[LSAB_SPARE_RELOAD_BIT];

  // ---------------------------------------------------------------------
  // Load switches
  // ---------------------------------------------------------------------
  logic [7:0] sw_rdata [2];
  logic [1:0] sw_wr;

  assign sw_wr = {wr_sw7, wr_sw6};

  // Both switches share one layout, so one module serves both. Only
  // bits 3:0 of a write reach a switch: the flags above are produced
  // inside and a host write cannot disturb them. Reload goes to both
  // at once, so a restore turns both switches off on the same edge.
  // The timeout counter runs inside each switch; its wait codes are
  // parameters so that a bench can shrink them, while in the device
  // they are the wait times counted in clock cycles.
  // One instance per switch, identical layout
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sw
      lsab_switch #(
        .WAIT0_CYC (WAIT0_CYC),
        .WAIT1_CYC (WAIT1_CYC),
        .WAIT2_CYC (WAIT2_CYC),
        .WAIT3_CYC (WAIT3_CYC)
      ) u_sw (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .reload_i    (reload),
        .wr_i        (sw_wr[g]),
        .wdata_i     (wdata_i[3:0]),
        .oc_i        (oc_s[g]),
        .ot_i        (ot_s[g]),
        .pg_i        (pg_s[g]),
        .limit_i     (lim_s[g]),
        .rdata_o     (sw_rdata[g]),
        .on_o        (switch_on_o[g]),
        .discharge_o (switch_discharge_o[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Converter control
  // ---------------------------------------------------------------------
  lsab_conv_state_e state_reg;
  lsab_conv_state_e state_next;
  logic             ref_reg;
  logic             ref_next;
  logic [3:0]       ch_reg;
  logic [3:0]       ch_next;
  logic             done_reg;
  logic             done_next;
  logic [9:0]       res_reg;
  logic [9:0]       res_next;
  logic             start_req;
  logic             finish;

  assign start_req = wr_conv && wdata_i[LSAB_CONV_START_BIT];
  assign finish    = (state_reg == LSAB_CONV_BUSY) && done_s;

  // The start bit that a host reads back is the busy state itself, so
  // it falls by itself on the edge after the synchronised completion
  // is seen. A second start while busy is not queued: the sequencer
  // stays where it is and only the reference and channel fields
  // change, so a host that wants a clean sample waits for done first.
  // Reload aborts a conversion; the converter sees start drop and
  // abandons its sample. Completion that is still seen high after a
  // reload finds the sequencer idle and is ignored.
  // Sequencer: start on host write, end on converter completion
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LSAB_CONV_IDLE: begin
        if (start_req) begin
          state_next = LSAB_CONV_BUSY;
        end
      end
      LSAB_CONV_BUSY: begin
        if (reload) begin
          state_next = LSAB_CONV_IDLE;
        end else if (done_s) begin
          state_next = LSAB_CONV_IDLE;
        end
      end
    endcase
  end

  assign ref_next  = reload ? 1'b0 :
                     wr_conv ? wdata_i[LSAB_CONV_REF_BIT] : ref_reg;
  assign ch_next   = reload ? 4'h0 :
                     wr_conv ? wdata_i[LSAB_CONV_CH_MSB:0] : ch_reg;
  // Both result halves change only on the finishing edge or a reload, so
  // a host that reads the result after done and before its next start
  // always sees the two halves of one sample.
  // Completion wins over a start write in the same cycle
  assign done_next = finish ? 1'b1 :
                     reload ? LSAB_CONV_DONE_RST :
                     (start_req && state_reg == LSAB_CONV_IDLE) ? 1'b0 :
                     done_reg;
  assign res_next  = finish ? conv_result_i :
                     reload ? LSAB_RESULT_RST : res_reg;

  // Done resets to one, so a host polling after power-up sees no
  // conversion pending and may start one at once
  // Converter storage
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= LSAB_CONV_IDLE;
      ref_reg   <= 1'b0;
      ch_reg    <= 4'h0;
      done_reg  <= LSAB_CONV_DONE_RST;
      res_reg   <= LSAB_RESULT_RST;
    end else begin
      state_reg <= state_next;
      ref_reg   <= ref_next;
      ch_reg    <= ch_next;
      done_reg  <= done_next;
      res_reg   <= res_next;
    end
  end

  // Start stays high toward the converter for the whole conversion
  assign conv_start_o   = (state_reg == LSAB_CONV_BUSY);
  assign conv_ref_en_o  = ref_reg;
  assign conv_channel_o = ch_reg;

  // ---------------------------------------------------------------------
  // Spare register
  // ---------------------------------------------------------------------
  logic [6:0] spare_reg;
  logic [6:0] spare_next;

  // The reload bit is never stored: it acts in the cycle of its write
  // and reads back as zero, so the host has no bit to clear afterwards
  // Reload clears storage even when written alongside
  assign spare_next = reload   ? LSAB_SPARE_RST :
                      wr_spare ? wdata_i[6:0] : spare_reg;

  // Spare storage
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spare_reg <= LSAB_SPARE_RST;
    end else begin
      spare_reg <= spare_next;
    end
  end

  // ---------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------
  logic [7:0] conv_rdata;
  logic [7:0] res_lo_rdata;
  logic [7:0] res_hi_rdata;
  logic [7:0] spare_rdata;

  // Register images; reserved positions are tied to zero
  assign conv_rdata = {1'b0, conv_start_o, done_reg, ref_reg, ch_reg};
  assign res_lo_rdata = res_reg[7:0];
  assign res_hi_rdata = {6'h00, res_reg[9:8]};
  assign spare_rdata  = {1'b0, spare_reg};

  // Reads are combinational from the address and have no side effect.
  // The switch images carry live flag levels, so two reads in a row
  // can differ while an analog condition comes and goes.
  assign rdata_o =
    sel_sw6    ? sw_rdata[0] :
    sel_sw7    ? sw_rdata[1] :
    sel_conv   ? conv_rdata :
    sel_res_lo ? res_lo_rdata :
    sel_res_hi ? res_hi_rdata :
    sel_spare  ? spare_rdata :
                 8'h00;

endmodule : lsab_bank
`default_nettype wire

// ---- core/lsab_pkg.sv ----
`default_nettype none
package lsab_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] LSAB_OFS_SW6    = 8'h14;
  localparam logic [7:0] LSAB_OFS_SW7    = 8'h15;
  localparam logic [7:0] LSAB_OFS_CONV   = 8'h16;
  localparam logic [7:0] LSAB_OFS_RES_LO = 8'h17;
  localparam logic [7:0] LSAB_OFS_RES_HI = 8'h18;
  localparam logic [7:0] LSAB_OFS_SPARE  = 8'h1B;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int LSAB_SW_TIMEOUT_BIT  = 7;
  localparam int LSAB_SW_OC_BIT       = 6;
  localparam int LSAB_SW_OT_BIT       = 5;
  localparam int LSAB_SW_PG_BIT       = 4;
  localparam int LSAB_SW_WAIT_MSB     = 3;
  localparam int LSAB_SW_WAIT_LSB     = 2;
  localparam int LSAB_SW_DISCH_BIT    = 1;
  localparam int LSAB_SW_ON_BIT       = 0;
  localparam int LSAB_CONV_START_BIT  = 6;
  localparam int LSAB_CONV_DONE_BIT   = 5;
  localparam int LSAB_CONV_REF_BIT    = 4;
  localparam int LSAB_CONV_CH_MSB     = 3;
  localparam int LSAB_SPARE_RELOAD_BIT = 7;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [3:0] LSAB_SW_CTRL_RST  = 4'h2;
  localparam logic       LSAB_CONV_DONE_RST = 1'b1;
  localparam logic [6:0] LSAB_SPARE_RST    = 7'h00;
  localparam logic [9:0] LSAB_RESULT_RST   = 10'h000;

  // ---------------------------------------------------------------------
  // Wait times and cycle counts
  // ---------------------------------------------------------------------
  localparam int LSAB_CLK_MHZ     = 40;
  localparam int LSAB_WAIT0_US    = 200;
  localparam int LSAB_WAIT1_US    = 800;
  localparam int LSAB_WAIT2_US    = 1600;
  localparam int LSAB_WAIT3_US    = 3200;
  localparam int LSAB_WAIT0_CYC   = LSAB_WAIT0_US * LSAB_CLK_MHZ;
  localparam int LSAB_WAIT1_CYC   = LSAB_WAIT1_US * LSAB_CLK_MHZ;
  localparam int LSAB_WAIT2_CYC   = LSAB_WAIT2_US * LSAB_CLK_MHZ;
  localparam int LSAB_WAIT3_CYC   = LSAB_WAIT3_US * LSAB_CLK_MHZ;
  localparam int LSAB_CNT_W       = 18;

  // Converter sequencing states
  typedef enum logic [0:0] {
    LSAB_CONV_IDLE = 1'b0,
    LSAB_CONV_BUSY = 1'b1
  } lsab_conv_state_e;

endpackage : lsab_pkg
`default_nettype wire

// ---- core/lsab_switch.sv ----
`timescale 1ns/100ps
`default_nettype none
module lsab_switch
  import lsab_pkg::*;
#(
  parameter int WAIT0_CYC = LSAB_WAIT0_CYC,
  parameter int WAIT1_CYC = LSAB_WAIT1_CYC,
  parameter int WAIT2_CYC = LSAB_WAIT2_CYC,
  parameter int WAIT3_CYC = LSAB_WAIT3_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       reload_i,
  input  wire logic       wr_i,
  input  wire logic [3:0] wdata_i,
  input  wire logic       oc_i,
  input  wire logic       ot_i,
  input  wire logic       pg_i,
  input  wire logic       limit_i,
  output logic      [7:0] rdata_o,
  output logic            on_o,
  output logic            discharge_o
);

  // ---------------------------------------------------------------------
  // Control field and timeout tracking
  // ---------------------------------------------------------------------
  logic [3:0]            ctrl_reg;
  logic [3:0]            ctrl_next;
  logic [LSAB_CNT_W-1:0] cnt_reg;
  logic [LSAB_CNT_W-1:0] cnt_next;
  logic                  to_reg;
  logic                  to_next;
  logic [LSAB_CNT_W-1:0] limit_cyc;
  logic                  limit_active;

  // Wait-time code selects the least time in current limit
  assign limit_cyc =
    (ctrl_reg[3:2] == 2'h0) ? LSAB_CNT_W'(WAIT0_CYC) :
    (ctrl_reg[3:2] == 2'h1) ? LSAB_CNT_W'(WAIT1_CYC) :
    (ctrl_reg[3:2] == 2'h2) ? LSAB_CNT_W'(WAIT2_CYC) :
                              LSAB_CNT_W'(WAIT3_CYC);
  assign limit_active = limit_i && ctrl_reg[0];
  assign ctrl_next = reload_i ? LSAB_SW_CTRL_RST :
                     wr_i     ? wdata_i : ctrl_reg;
  assign cnt_next  = !limit_active ? '0 :
                     (cnt_reg < limit_cyc) ? cnt_reg + 1'b1 : cnt_reg;
  // Timeout latches until switch is turned off or reloaded
  assign to_next   = (limit_active && cnt_reg >= limit_cyc) ? 1'b1 :
                     (reload_i || !ctrl_next[0]) ? 1'b0 : to_reg;

  // Storage
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= LSAB_SW_CTRL_RST;
      cnt_reg  <= '0;
      to_reg   <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      cnt_reg  <= cnt_next;
      to_reg   <= to_next;
    end
  end

  // Read image: flags above, control below
  assign rdata_o     = {to_reg, oc_i, ot_i, pg_i, ctrl_reg};
  assign on_o        = ctrl_reg[0] && !to_reg;
  assign discharge_o = ctrl_reg[1];

endmodule : lsab_switch
`default_nettype wire

// ---- dv/lsab_bank_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module lsab_bank_tb
  import lsab_pkg::*;
  ;
  localparam int WT [4] = '{8, 16, 32, 64};
  logic       clk_sys_i = 1'b0;
  logic       nrst_i    = 1'b0;
  logic [7:0] addr_i    = 8'h00;
  logic       wr_en_i   = 1'b0;
  logic [7:0] wdata_i   = 8'h00;
  logic [1:0] sw_oc_i   = 2'h0;
  logic [1:0] sw_ot_i   = 2'h0;
  logic [1:0] sw_pg_i   = 2'h0;
  logic [1:0] lim_i     = 2'h0;
  logic [3:0] dly       = 4'h1;
  logic [9:0] val       = 10'h2A5;
  logic [7:0] rdata_o;
  logic [1:0] on_o;
  logic [1:0] dis_o;
  logic       start_o;
  logic       ref_o;
  logic       cmpl;
  logic [3:0] ch_o;
  logic [9:0] res;
  int         n_errors    = 0;
  int         checks_done = 0;
  // ----
  // Bench
  // ----
  lsab_bank #(.WAIT0_CYC(WT[0]), .WAIT1_CYC(WT[1]), .WAIT2_CYC(WT[2]),
    .WAIT3_CYC(WT[3])) u_dut (.clk_sys_i, .nrst_i, .addr_i, .wr_en_i,
    .wdata_i, .rdata_o, .sw_oc_i, .sw_ot_i, .sw_pg_i, .sw_limit_i(lim_i),
    .switch_on_o(on_o), .switch_discharge_o(dis_o), .conv_start_o(start_o),
    .conv_ref_en_o(ref_o), .conv_channel_o(ch_o), .conv_complete_i(cmpl),
    .conv_result_i(res));
  lsab_conv_model u_conv (.clk_sys_i, .start_i(start_o), .delay_i(dly),
    .value_i(val), .complete_o(cmpl), .result_o(res));
  // Clock
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: addr %h rdata %h", $time, addr_i, rdata_o);
    end
  endtask : chk
  // One write strobe, held across a single rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr_i  = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    @(negedge clk_sys_i);
    wr_en_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    addr_i = a;
    #1;
    chk(rdata_o === e);
  endtask : rd
  task automatic defaults;
    rd(LSAB_OFS_SW6, 8'h02);
    rd(LSAB_OFS_SW7, 8'h02);
    rd(LSAB_OFS_CONV, 8'h20);
    rd(LSAB_OFS_RES_LO, 8'h00);
    rd(LSAB_OFS_RES_HI, 8'h00);
    rd(LSAB_OFS_SPARE, 8'h00);
  endtask : defaults
  // Bounded wait for the conversion to end, then let completion drop
  task automatic wait_idle;
    for (int i = 0; i < 100 && start_o !== 1'b0; i++) @(negedge clk_sys_i);
    chk(start_o === 1'b0);
    repeat (6) @(negedge clk_sys_i);
  endtask : wait_idle
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // Watchdog
  initial begin
    #500000;
    n_errors++;
    give_verdict;
  end
  // Tests
  initial begin
    repeat (6) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    defaults;
    rd(8'h19, 8'h00);
    $display("test reset done");
    wr(LSAB_OFS_SW6, 8'hFF);
    rd(LSAB_OFS_SW6, 8'h0F);
    wr(LSAB_OFS_SW7, 8'hF6);
    rd(LSAB_OFS_SW7, 8'h06);
    wr(LSAB_OFS_SPARE, 8'h55);
    rd(LSAB_OFS_SPARE, 8'h55);
    wr(LSAB_OFS_RES_HI, 8'hFF);
    wr(8'h19, 8'hFF);
    rd(LSAB_OFS_RES_HI, 8'h00);
    rd(8'h19, 8'h00);
    sw_oc_i = 2'h1;
    sw_ot_i = 2'h2;
    sw_pg_i = 2'h3;
    repeat (3) @(negedge clk_sys_i);
    rd(LSAB_OFS_SW6, 8'h5F);
    rd(LSAB_OFS_SW7, 8'h36);
    chk(on_o === 2'b01 && dis_o === 2'b11);
    sw_oc_i = 2'h0;
    sw_ot_i = 2'h0;
    sw_pg_i = 2'h0;
    for (int c = 0; c < 16; c++) begin
      wr(LSAB_OFS_CONV, {3'h4, c[0], c[3:0]});
      rd(LSAB_OFS_CONV, {3'h1, c[0], c[3:0]});
      chk(ref_o === c[0] && ch_o === c[3:0]);
    end
    $display("test access done");
    wr(LSAB_OFS_CONV, 8'h43);
    rd(LSAB_OFS_CONV, 8'h43);
    wait_idle;
    rd(LSAB_OFS_CONV, 8'h23);
    rd(LSAB_OFS_RES_LO, 8'hA5);
    rd(LSAB_OFS_RES_HI, 8'h02);
    dly = 4'h9;
    val = 10'h15A;
    wr(LSAB_OFS_CONV, 8'h45);
    rd(LSAB_OFS_RES_LO, 8'hA5);
    wait_idle;
    rd(LSAB_OFS_RES_LO, 8'h5A);
    rd(LSAB_OFS_RES_HI, 8'h01);
    $display("test conversion done");
    wr(LSAB_OFS_SW7, 8'h0D);
    wr(LSAB_OFS_CONV, 8'h5C);
    wr(LSAB_OFS_SPARE, 8'hFF);
    repeat (6) @(negedge clk_sys_i);
    defaults;
    $display("test reload done");
    for (int w = 0; w < 4; w++) begin
      wr(LSAB_OFS_SW6, {4'h0, w[1:0], 2'h1});
      lim_i = 2'h1;
      repeat (WT[w] - 2) @(negedge clk_sys_i);
      rd(LSAB_OFS_SW6, {4'h0, w[1:0], 2'h1});
      repeat (6) @(negedge clk_sys_i);
      rd(LSAB_OFS_SW6, {4'h8, w[1:0], 2'h1});
      chk(on_o === 2'b00 && dis_o === 2'b10);
      lim_i = 2'h0;
      wr(LSAB_OFS_SW6, 8'h00);
      rd(LSAB_OFS_SW6, 8'h00);
    end
    $display("test timeout done");
    give_verdict;
  end
endmodule : lsab_bank_tb
`default_nettype wire

// ---- dv/lsab_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module lsab_chk
  import lsab_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_en_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] switch_on_o,
  input wire logic [1:0] switch_discharge_o,
  input wire logic       conv_start_o,
  input wire logic       conv_ref_en_o,
  input wire logic [3:0] conv_channel_o,
  input wire logic       conv_complete_i
);
  // ----
  // Port relations
  // ----
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Converter idle long enough that no stale completion is in flight
  sequence s_quiet;
    !conv_complete_i [*3];
  endsequence
  sequence s_start_wr;
    wr_en_i && addr_i == LSAB_OFS_CONV && wdata_i[6] && !conv_start_o;
  endsequence
  AST_START_SET: assert property (
    s_quiet ##0 s_start_wr |=> conv_start_o)
    else $error("start write did not start a conversion");
  AST_START_CLR: assert property (
    $rose(conv_complete_i) && conv_start_o |-> ##[1:4] !conv_start_o)
    else $error("start bit not cleared after completion");
  AST_DONE: assert property (
    addr_i == LSAB_OFS_CONV |->
      rdata_o[6] == conv_start_o && rdata_o[5] != conv_start_o)
    else $error("done and start bits disagree");
  AST_CONV_OUT: assert property (
    addr_i == LSAB_OFS_CONV |-> !rdata_o[7] &&
      conv_ref_en_o == rdata_o[4] && conv_channel_o == rdata_o[3:0])
    else $error("converter outputs differ from register");
  AST_RESV_HI: assert property (
    addr_i == LSAB_OFS_RES_HI |-> rdata_o[7:2] == 6'h00)
    else $error("reserved result bits not zero");
  AST_SPARE_B7: assert property (
    addr_i == LSAB_OFS_SPARE |-> !rdata_o[7])
    else $error("reload bit reads one");
  AST_SW_WR: assert property (
    wr_en_i && addr_i == LSAB_OFS_SW6 |=>
      addr_i != LSAB_OFS_SW6 || rdata_o[3:0] == $past(wdata_i[3:0]))
    else $error("switch write not stored");
  AST_SW6_OUT: assert property (
    addr_i == LSAB_OFS_SW6 |->
      switch_on_o[0] == (rdata_o[0] && !rdata_o[7]) &&
      switch_discharge_o[0] == rdata_o[1])
    else $error("switch6 drive differs from register");
  AST_SW7_OUT: assert property (
    addr_i == LSAB_OFS_SW7 |->
      switch_on_o[1] == (rdata_o[0] && !rdata_o[7]) &&
      switch_discharge_o[1] == rdata_o[1])
    else $error("switch7 drive differs from register");
  AST_RELOAD: assert property (
    wr_en_i && addr_i == LSAB_OFS_SPARE && wdata_i[7] |=>
      !conv_start_o && switch_on_o == 2'b00 &&
      switch_discharge_o == 2'b11 && conv_channel_o == 4'h0)
    else $error("reload did not restore defaults");
endmodule : lsab_chk
bind lsab_bank lsab_chk u_chk (.clk_sys_i, .nrst_i, .addr_i, .wr_en_i,
  .wdata_i, .rdata_o, .switch_on_o, .switch_discharge_o, .conv_start_o,
  .conv_ref_en_o, .conv_channel_o, .conv_complete_i);
`default_nettype wire

// ---- dv/lsab_conv_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module lsab_conv_model (
  input  wire logic       clk_sys_i,
  input  wire logic       start_i,
  input  wire logic [3:0] delay_i,
  input  wire logic [9:0] value_i,
  output logic            complete_o,
  output logic      [9:0] result_o
);
  logic [3:0] cnt_reg;
  // ----
  // Converter
  // ----
  // Completes delay_i + 1 cycles after start, drops once start is gone
  always_ff @(posedge clk_sys_i) begin
    if (!start_i) begin
      cnt_reg    <= 4'h0;
      complete_o <= 1'b0;
    end else if (cnt_reg >= delay_i) begin
      complete_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // Result is garbage unless complete is up
  assign result_o = complete_o ? value_i : ~value_i;
endmodule : lsab_conv_model
`default_nettype wire
